// ---- cmb_pkg.sv ----
// Constants shared by the converter mode control bank.
// Assumes a single 25 MHz clock domain and a 16-bit register map.
package cmb_pkg;

	// Clock rate of the control logic.
	localparam int CMB_CLK_MHZ = 25;

	// Register indices on the serial control port.
	localparam logic [3:0] CMB_REG_MAIN     = 4'h0;
	localparam logic [3:0] CMB_REG_I_OFS    = 4'h2;
	localparam logic [3:0] CMB_REG_I_FSR    = 4'h3;
	localparam logic [3:0] CMB_REG_CAL      = 4'h4;
	localparam logic [3:0] CMB_REG_SKEW     = 4'h7;
	localparam logic [3:0] CMB_REG_Q_OFS    = 4'hA;
	localparam logic [3:0] CMB_REG_Q_FSR    = 4'hB;
	localparam logic [3:0] CMB_REG_PH_CRS   = 4'hC;
	localparam logic [3:0] CMB_REG_PH_FINE  = 4'hD;
	localparam logic [3:0] CMB_REG_SYNC     = 4'hE;

	// One bit per implemented register index.
	localparam logic [15:0] CMB_MAPPED = 16'h7C9D;

	// Main configuration register fields.
	localparam int CMB_B_CAL        = 15;
	localparam int CMB_B_PHASE      = 14;
	localparam int CMB_B_SWING      = 13;
	localparam int CMB_B_TEST       = 12;
	localparam int CMB_B_PD_FIRST   = 11;
	localparam int CMB_B_PD_SECOND  = 10;
	localparam int CMB_B_INTERLEAVE = 7;
	localparam int CMB_B_BOTH_IN    = 6;
	localparam int CMB_B_SECOND_IN  = 5;
	localparam int CMB_B_TWOS       = 4;
	localparam int CMB_B_STAMP      = 3;
	localparam int CMB_B_SDR        = 2;

	// Calibration adjust field.
	localparam int CMB_B_CAL_ACCESS = 7;

	// Sampling clock phase adjust enable in the coarse register.
	localparam int CMB_B_PH_EN = 15;

	// Synchronization register fields.
	localparam int CMB_B_SECONDARY = 10;
	localparam int CMB_B_RCO_TWO   = 9;
	localparam int CMB_B_RCO_ONE   = 8;
	localparam int CMB_B_DUAL_CLK  = 6;
	localparam int CMB_B_DCLK_RST  = 0;

	// Full-scale words for the range pin: high is mid scale, low is minimum.
	localparam logic [15:0] CMB_FSR_MID = 16'h4000;
	localparam logic [15:0] CMB_FSR_MIN = 16'h0000;

	// Reset values; the main register defaults to the higher output swing.
	localparam logic [15:0] CMB_REG_RESET [16] = '{
		16'h2000, 16'h0000, 16'h0000, CMB_FSR_MID,
		16'h0000, 16'h0000, 16'h0000, 16'h0040,
		16'h0000, 16'h0000, 16'h0000, CMB_FSR_MID,
		16'h0000, 16'h0000, 16'h0000, 16'h0000
	};

	// Serial frame: 8 header bits (read flag, address) and 16 data bits.
	localparam logic [4:0] CMB_HDR_BITS   = 5'h08;
	localparam logic [4:0] CMB_FRAME_BITS = 5'h18;
	localparam int         CMB_RW_POS     = 6;

	// Pin synchronizer lanes.
	localparam int CMB_P_EXT    = 0;
	localparam int CMB_P_IL     = 1;
	localparam int CMB_P_FSR    = 2;
	localparam int CMB_P_PHASE  = 3;
	localparam int CMB_P_TEST   = 4;
	localparam int CMB_P_CAL    = 5;
	localparam int CMB_P_PD1    = 6;
	localparam int CMB_P_PD2    = 7;
	localparam int CMB_P_DEMUX  = 8;
	localparam int CMB_P_SCS_N  = 9;
	localparam int CMB_P_SCLK   = 10;
	localparam int CMB_P_SDI    = 11;
	localparam int CMB_PIN_W    = 12;

endpackage

// ---- cmb_pin_sync.sv ----
// Two-stage synchronizers for the static control pins and serial pins.
// Assumes the pins are asynchronous to clk.
module cmb_pin_sync
	import cmb_pkg::*;
(
	// Clock and reset.
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Raw pins and their synchronized copies.
	input  wire logic [CMB_PIN_W-1:0] pin_raw,
	output logic      [CMB_PIN_W-1:0] pin_sync
);

	logic [CMB_PIN_W-1:0] meta_ff;
	logic [CMB_PIN_W-1:0] sync_ff;

	// The chip select lane idles high, all others low.
	for (genvar i = 0; i < CMB_PIN_W; i++) begin : g_lane
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				meta_ff[i] <= (i == CMB_P_SCS_N);
				sync_ff[i] <= (i == CMB_P_SCS_N);
			end else begin
				meta_ff[i] <= pin_raw[i];
				sync_ff[i] <= meta_ff[i];
			end
		end
	end

	assign pin_sync = sync_ff;

endmodule

// ---- cmb_serial_port.sv ----
// Serial control port slave: 8-bit header then 16 data bits, MSB first.
// Assumes synchronized pins; data sampled on rising serial clock edges.
module cmb_serial_port
	import cmb_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst,
	// Synchronized serial pins.
	input  wire logic        scs_n_s,
	input  wire logic        sclk_s,
	input  wire logic        sdi_s,
	// Register access.
	input  wire logic [15:0] rd_data,
	output logic             wr_en,
	output logic      [3:0]  addr,
	output logic      [15:0] wr_data,
	// Serial data out with its enable.
	output logic             sdo,
	output logic             sdo_oe
);

	logic        sclk_d_ff;
	logic [4:0]  cnt_ff;
	logic [15:0] shift_ff;
	logic        rd_ff;
	logic [3:0]  addr_ff;
	logic [15:0] out_ff;
	logic        wr_en_ff;
	logic [15:0] wr_data_ff;
	logic        sdo_ff;
	logic        sdo_oe_ff;
	logic        rise;
	logic        fall;

	assign rise = sclk_s & ~sclk_d_ff;
	assign fall = ~sclk_s & sclk_d_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_d_ff <= 1'b0;
		end else begin
			sclk_d_ff <= sclk_s;
		end
	end

	// Shifts in the header and write data; a write lands after the last bit.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff     <= 5'h00;
			shift_ff   <= 16'h0000;
			rd_ff      <= 1'b0;
			addr_ff    <= 4'h0;
			wr_en_ff   <= 1'b0;
			wr_data_ff <= 16'h0000;
		end else begin
			wr_en_ff <= 1'b0;
			if (scs_n_s) begin
				cnt_ff <= 5'h00;
			end else if (rise && cnt_ff < CMB_FRAME_BITS) begin
				shift_ff <= {shift_ff[14:0], sdi_s};
				cnt_ff   <= cnt_ff + 5'h01;
				if (cnt_ff == CMB_HDR_BITS - 5'h01) begin
					rd_ff   <= shift_ff[CMB_RW_POS - 1];
					addr_ff <= {shift_ff[2:0], sdi_s};
				end
				if (cnt_ff == CMB_FRAME_BITS - 5'h01 && !rd_ff) begin
					wr_en_ff   <= 1'b1;
					wr_data_ff <= {shift_ff[14:0], sdi_s};
				end
			end
		end
	end

	// Read data leave on falling serial clock edges after the header.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_ff    <= 16'h0000;
			sdo_ff    <= 1'b0;
			sdo_oe_ff <= 1'b0;
		end else if (scs_n_s) begin
			sdo_ff    <= 1'b0;
			sdo_oe_ff <= 1'b0;
		end else if (fall && rd_ff && cnt_ff >= CMB_HDR_BITS
				&& cnt_ff < CMB_FRAME_BITS) begin
			sdo_oe_ff <= 1'b1;
			if (cnt_ff == CMB_HDR_BITS) begin
				sdo_ff <= rd_data[15];
				out_ff <= {rd_data[14:0], 1'b0};
			end else begin
				sdo_ff <= out_ff[15];
				out_ff <= {out_ff[14:0], 1'b0};
			end
		end
	end

	assign wr_en   = wr_en_ff;
	assign addr    = addr_ff;
	assign wr_data = wr_data_ff;
	assign sdo     = sdo_ff;
	assign sdo_oe  = sdo_oe_ff;

endmodule

// ---- cmb_mode_control.sv ----
// Mode and configuration control bank of a dual-channel sampling converter.
// Assumes control pins and serial pins are asynchronous to clk.

// Notes on behaviour
// - Two schemes: static pins, or extended registers over the serial port.
// - Interleave follows its pin in pin mode, main bit 7 in extended.
// - Main bits 6:5 pick interleave input in extended mode only.
// - Dual-clock interleave from sync register bit 6, extended only.
// - Range follows its pin, else registers 3h and Bh, default mid.
// - Output phase follows its pin, else main bit 14, default zero.
// - Main bit 2 selects SDR in extended; pin mode always DDR.
// - Main bit 13 picks swing in extended; pin mode always higher.
// - Main bit 4 picks two's complement; pin mode offset binary.
// - Test pattern follows its pin, else main bit 12, default off.
// - Time stamp only in extended mode through main bit 3, default off.
// - Calibration starts from its pin always, or main bit 15 in extended.
// - Register 4h adjusts calibration; bit 7 enables value access.
// - First channel powers down by pin, or main bit 11 in extended.
// - Second channel powers down by pin, or main bit 10 in extended.
// - Demux bypass follows only its pin, in both modes.
// - Synchronization set by register Eh in extended, default primary.
module cmb_mode_control
	import cmb_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst,
	// Static control pins.
	input  wire logic        extended_control_scheme,
	input  wire logic        interleave_pin,
	input  wire logic        range_select_pin,
	input  wire logic        output_phase_pin,
	input  wire logic        test_pattern_pin,
	input  wire logic        cal_pin,
	input  wire logic        first_powerdown_pin,
	input  wire logic        second_powerdown_pin,
	input  wire logic        demux_bypass_pin,
	// Serial control port.
	input  wire logic        scs_n,
	input  wire logic        sclk,
	input  wire logic        sdi,
	output logic             sdo,
	output logic             sdo_oe,
	// Input path controls.
	output logic             extended_mode_active,
	output logic             interleave_en,
	output logic             interleave_use_second_input,
	output logic             interleave_use_both_inputs,
	output logic             dual_clock_interleave,
	output logic      [15:0] i_full_scale,
	output logic      [15:0] q_full_scale,
	output logic      [15:0] i_offset,
	output logic      [15:0] q_offset,
	output logic      [15:0] skew_trim,
	output logic             clk_phase_adjust_en,
	output logic      [15:0] clk_phase_coarse,
	output logic      [15:0] clk_phase_fine,
	// Output path controls.
	output logic             output_phase_select,
	output logic             sdr_select,
	output logic             output_swing_low,
	output logic             twos_complement_select,
	output logic             test_pattern_enable,
	output logic             timestamp_enable,
	output logic             demux_bypass,
	// Calibration.
	output logic             cal_start,
	output logic      [15:0] cal_adjust,
	output logic             cal_value_access_enable,
	// Power down.
	output logic             first_channel_powerdown,
	output logic             second_channel_powerdown,
	// Synchronization.
	output logic      [15:0] sync_config,
	output logic             sync_secondary_role,
	output logic             ref_clock_output_one,
	output logic             ref_clock_output_two,
	output logic             dclk_reset
);

	logic [CMB_PIN_W-1:0] pin_s;
	logic                 ext_s;
	logic                 wr_en;
	logic [3:0]           wr_addr;
	logic [15:0]          wr_data;
	logic [15:0]          rd_data;
	logic [15:0]          cfg_ff [16];
	logic [15:0]          eff [16];
	logic                 cal_pin_d_ff;
	logic                 cal_bit_d_ff;
	logic [15:0]          main_w;
	logic                 nxt_cal_start;

	cmb_pin_sync u_sync (
		.clk      (clk),
		.rst      (rst),
		.pin_raw  ({sdi, sclk, scs_n, demux_bypass_pin,
			second_powerdown_pin, first_powerdown_pin, cal_pin,
			test_pattern_pin, output_phase_pin, range_select_pin,
			interleave_pin, extended_control_scheme}),
		.pin_sync (pin_s)
	);

	assign ext_s = pin_s[CMB_P_EXT];

	cmb_serial_port u_port (
		.clk     (clk),
		.rst     (rst),
		.scs_n_s (pin_s[CMB_P_SCS_N]),
		.sclk_s  (pin_s[CMB_P_SCLK]),
		.sdi_s   (pin_s[CMB_P_SDI]),
		.rd_data (rd_data),
		.wr_en   (wr_en),
		.addr    (wr_addr),
		.wr_data (wr_data),
		.sdo     (sdo),
		.sdo_oe  (sdo_oe)
	);

	// Registers accept writes in either mode but act only in extended mode.
	for (genvar i = 0; i < 16; i++) begin : g_reg
		if (CMB_MAPPED[i]) begin : g_impl
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					cfg_ff[i] <= CMB_REG_RESET[i];
				end else if (wr_en && wr_addr == 4'(i)) begin
					cfg_ff[i] <= wr_data;
				end
			end
		end else begin : g_hole
			assign cfg_ff[i] = 16'h0000;
		end
		assign eff[i] = ext_s ? cfg_ff[i] : CMB_REG_RESET[i];
	end

	assign rd_data = cfg_ff[wr_addr];

	// Main register view with pin-mode features forced from pins.
	always_comb begin
		main_w = eff[CMB_REG_MAIN];
		if (!ext_s) begin
			main_w[CMB_B_INTERLEAVE] = pin_s[CMB_P_IL];
			main_w[CMB_B_PHASE]      = pin_s[CMB_P_PHASE];
			main_w[CMB_B_TEST]       = pin_s[CMB_P_TEST];
		end
		main_w[CMB_B_PD_FIRST]  = main_w[CMB_B_PD_FIRST]
			| pin_s[CMB_P_PD1];
		main_w[CMB_B_PD_SECOND] = main_w[CMB_B_PD_SECOND]
			| pin_s[CMB_P_PD2];
	end

	// Calibration starts on a rising pin or a rising register bit.
	assign nxt_cal_start = (pin_s[CMB_P_CAL] & ~cal_pin_d_ff)
		| (ext_s & cfg_ff[CMB_REG_MAIN][CMB_B_CAL] & ~cal_bit_d_ff);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cal_pin_d_ff <= 1'b0;
			cal_bit_d_ff <= 1'b0;
			cal_start    <= 1'b0;
		end else begin
			cal_pin_d_ff <= pin_s[CMB_P_CAL];
			cal_bit_d_ff <= cfg_ff[CMB_REG_MAIN][CMB_B_CAL];
			cal_start    <= nxt_cal_start;
		end
	end

	// Input path controls.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			extended_mode_active        <= 1'b0;
			interleave_en               <= 1'b0;
			interleave_use_second_input <= 1'b0;
			interleave_use_both_inputs  <= 1'b0;
			dual_clock_interleave       <= 1'b0;
			i_full_scale                <= CMB_REG_RESET[CMB_REG_I_FSR];
			q_full_scale                <= CMB_REG_RESET[CMB_REG_Q_FSR];
			i_offset                    <= CMB_REG_RESET[CMB_REG_I_OFS];
			q_offset                    <= CMB_REG_RESET[CMB_REG_Q_OFS];
			skew_trim                   <= CMB_REG_RESET[CMB_REG_SKEW];
			clk_phase_adjust_en         <= 1'b0;
			clk_phase_coarse            <= CMB_REG_RESET[CMB_REG_PH_CRS];
			clk_phase_fine              <= CMB_REG_RESET[CMB_REG_PH_FINE];
		end else begin
			extended_mode_active        <= ext_s;
			interleave_en               <= main_w[CMB_B_INTERLEAVE];
			interleave_use_second_input <= main_w[CMB_B_SECOND_IN];
			interleave_use_both_inputs  <= main_w[CMB_B_BOTH_IN];
			dual_clock_interleave <= eff[CMB_REG_SYNC][CMB_B_DUAL_CLK];
			if (ext_s) begin
				i_full_scale <= cfg_ff[CMB_REG_I_FSR];
				q_full_scale <= cfg_ff[CMB_REG_Q_FSR];
			end else begin
				i_full_scale <= pin_s[CMB_P_FSR] ? CMB_FSR_MID
					: CMB_FSR_MIN;
				q_full_scale <= pin_s[CMB_P_FSR] ? CMB_FSR_MID
					: CMB_FSR_MIN;
			end
			i_offset            <= eff[CMB_REG_I_OFS];
			q_offset            <= eff[CMB_REG_Q_OFS];
			skew_trim           <= eff[CMB_REG_SKEW];
			clk_phase_adjust_en <= eff[CMB_REG_PH_CRS][CMB_B_PH_EN];
			clk_phase_coarse    <= eff[CMB_REG_PH_CRS];
			clk_phase_fine      <= eff[CMB_REG_PH_FINE];
		end
	end

	// Output path, calibration, power and synchronization controls.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			output_phase_select      <= 1'b0;
			sdr_select               <= 1'b0;
			output_swing_low         <= 1'b0;
			twos_complement_select   <= 1'b0;
			test_pattern_enable      <= 1'b0;
			timestamp_enable         <= 1'b0;
			demux_bypass             <= 1'b0;
			cal_adjust               <= CMB_REG_RESET[CMB_REG_CAL];
			cal_value_access_enable  <= 1'b0;
			first_channel_powerdown  <= 1'b0;
			second_channel_powerdown <= 1'b0;
			sync_config              <= CMB_REG_RESET[CMB_REG_SYNC];
			sync_secondary_role      <= 1'b0;
			ref_clock_output_one     <= 1'b0;
			ref_clock_output_two     <= 1'b0;
			dclk_reset               <= 1'b0;
		end else begin
			output_phase_select    <= main_w[CMB_B_PHASE];
			sdr_select             <= main_w[CMB_B_SDR];
			// Stored bit is one for the higher swing.
			output_swing_low       <= ~main_w[CMB_B_SWING];
			twos_complement_select <= main_w[CMB_B_TWOS];
			test_pattern_enable    <= main_w[CMB_B_TEST];
			timestamp_enable       <= main_w[CMB_B_STAMP];
			demux_bypass           <= pin_s[CMB_P_DEMUX];
			cal_adjust             <= eff[CMB_REG_CAL];
			cal_value_access_enable <=
				eff[CMB_REG_CAL][CMB_B_CAL_ACCESS];
			first_channel_powerdown  <= main_w[CMB_B_PD_FIRST];
			second_channel_powerdown <= main_w[CMB_B_PD_SECOND];
			sync_config          <= eff[CMB_REG_SYNC];
			sync_secondary_role  <= eff[CMB_REG_SYNC][CMB_B_SECONDARY];
			ref_clock_output_one <= eff[CMB_REG_SYNC][CMB_B_RCO_ONE];
			ref_clock_output_two <= eff[CMB_REG_SYNC][CMB_B_RCO_TWO];
			dclk_reset           <= eff[CMB_REG_SYNC][CMB_B_DCLK_RST];
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_interleave_pin: assert property (
		!ext_s |=> interleave_en == $past(pin_s[CMB_P_IL]))
		else $error("interleave does not follow its pin");

	chk_range_pin: assert property (
		!ext_s ##1 !ext_s |-> i_full_scale == ($past(pin_s[CMB_P_FSR], 1)
			? CMB_FSR_MID : CMB_FSR_MIN))
		else $error("range does not follow its pin");

	chk_dual_clk_off: assert property (
		!ext_s |=> !dual_clock_interleave)
		else $error("dual clock interleave active in pin mode");

	chk_ddr_only_pin: assert property (
		!ext_s |=> !sdr_select && !output_swing_low)
		else $error("SDR or low swing active in pin mode");

	chk_format_pin: assert property (
		!ext_s |=> !twos_complement_select && !timestamp_enable)
		else $error("pin mode format or stamp wrong");

	chk_phase_ext: assert property (
		ext_s |=> output_phase_select == $past(cfg_ff[0][CMB_B_PHASE]))
		else $error("output phase does not follow register");

	chk_cal_pin_edge: assert property (
		$rose(pin_s[CMB_P_CAL]) |=> cal_start ##1 !cal_start
			|| ($past(ext_s && cfg_ff[0][CMB_B_CAL])
			&& !$past(cfg_ff[0][CMB_B_CAL], 2)))
		else $error("calibration pin edge lost");

	chk_pd_first: assert property (
		pin_s[CMB_P_PD1] |=> first_channel_powerdown)
		else $error("first channel not powered down by pin");

	chk_pd_second: assert property (
		(ext_s && cfg_ff[0][CMB_B_PD_SECOND]) || pin_s[CMB_P_PD2]
		|=> second_channel_powerdown)
		else $error("second channel not powered down");

	chk_demux_pin: assert property (
		##1 demux_bypass == $past(pin_s[CMB_P_DEMUX]))
		else $error("demux bypass does not follow its pin");

endmodule

// ---- cmb_host_model.sv ----
// Host controller model for the serial control port of the mode bank.
// Assumes it shares clk with the bench; sclk phases last 4 clk or more.
module cmb_host_model
	import cmb_pkg::*;
(
	// Clock.
	input  wire logic clk,
	// Serial control port.
	output logic      scs_n,
	output logic      sclk,
	output logic      sdi,
	input  wire logic sdo
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		scs_n = 1'b1;
		sclk  = 1'b0;
		sdi   = 1'b0;
	end

	// Sends the first nb bits of a frame; fewer than 24 cuts the frame short.
	task automatic xfer(input logic rd, input logic [3:0] a,
		input logic [15:0] d, input int nb, output logic [15:0] q);
		logic [23:0] f;
		f = {1'b0, rd, 2'b00, a, d};
		q = 16'h0000;
		@(posedge clk);
		scs_n <= 1'b0;
		for (int i = 23; i > 23 - nb; i--) begin
			repeat (4) @(posedge clk);
			sdi <= f[i];
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
			repeat (5) @(posedge clk);
			if (i <= 16 && i >= 1)
				q[i-1] = sdo;
		end
		repeat (4) @(posedge clk);
		scs_n <= 1'b1;
		// A released data line must not keep looking valid.
		sdi <= ~sdi;
		// Lets the chip select release pass the synchronizer before returning.
		repeat (8) @(posedge clk);
	endtask
endmodule

// ---- converter_mode_control_bank_tb_top.sv ----
// Self-checking bench for the converter mode control bank.
// Assumes a 25 MHz clock and the host model on the serial port.
module converter_mode_control_bank_tb_top
	import cmb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
	n_mismatch++; $display("mismatch %s exp %h got %h", n, e, g); end end

	typedef struct packed {
		logic [3:0]  a;
		logic [15:0] d;
		logic [3:0]  s;
		logic [15:0] e;
	} cmb_row_t;

	logic clk = 1'b0, rst = 1'b1, extended_control_scheme = 1'b1;
	logic interleave_pin = 1'b0, range_select_pin = 1'b1, cal_pin = 1'b0;
	logic output_phase_pin = 1'b0, test_pattern_pin = 1'b0;
	logic first_powerdown_pin = 1'b0, second_powerdown_pin = 1'b0;
	logic demux_bypass_pin = 1'b0;
	logic scs_n, sclk, sdi, sdo, sdo_oe, extended_mode_active, interleave_en;
	logic interleave_use_second_input, interleave_use_both_inputs, dclk_reset;
	logic dual_clock_interleave, clk_phase_adjust_en, output_phase_select;
	logic sdr_select, output_swing_low, twos_complement_select, cal_start;
	logic test_pattern_enable, timestamp_enable, demux_bypass;
	logic cal_value_access_enable, first_channel_powerdown;
	logic second_channel_powerdown, sync_secondary_role;
	logic ref_clock_output_one, ref_clock_output_two;
	logic [15:0] i_full_scale, q_full_scale, i_offset, q_offset, skew_trim;
	logic [15:0] clk_phase_coarse, clk_phase_fine, cal_adjust, sync_config;
	logic [15:0] rb;
	int n_mismatch = 0, num_checks = 0, cyc = 0, n_cal = 0, c0;
	int n_oe = 0;

	cmb_row_t rows [13] = '{
		'{4'h0, 16'h7CFC, 4'h0, 16'h7CFC},
		'{4'h0, 16'h2000, 4'h0, 16'h2000},
		'{4'h2, 16'h1234, 4'h2, 16'h1234},
		'{4'hA, 16'h0FED, 4'hA, 16'h0FED},
		'{4'h3, 16'h7FFF, 4'h3, 16'h7FFF},
		'{4'hB, 16'h0001, 4'hB, 16'h0001},
		'{4'h7, 16'h007F, 4'h7, 16'h007F},
		'{4'hD, 16'h00AA, 4'hD, 16'h00AA},
		'{4'h4, 16'h0080, 4'hF, 16'h0020},
		'{4'hC, 16'h8005, 4'hF, 16'h0060},
		'{4'hE, 16'h0747, 4'hF, 16'h007F},
		'{4'hE, 16'h0000, 4'hF, 16'h0060},
		'{4'h1, 16'hFFFF, 4'hF, 16'h0060}
	};

	always #20 clk = ~clk;

	cmb_mode_control dut_u (
		.clk, .rst, .extended_control_scheme, .interleave_pin,
		.range_select_pin, .output_phase_pin, .test_pattern_pin, .cal_pin,
		.first_powerdown_pin, .second_powerdown_pin, .demux_bypass_pin,
		.scs_n, .sclk, .sdi, .sdo, .sdo_oe, .extended_mode_active,
		.interleave_en, .interleave_use_second_input,
		.interleave_use_both_inputs, .dual_clock_interleave, .i_full_scale,
		.q_full_scale, .i_offset, .q_offset, .skew_trim, .clk_phase_adjust_en,
		.clk_phase_coarse, .clk_phase_fine, .output_phase_select, .sdr_select,
		.output_swing_low, .twos_complement_select, .test_pattern_enable,
		.timestamp_enable, .demux_bypass, .cal_start, .cal_adjust,
		.cal_value_access_enable, .first_channel_powerdown,
		.second_channel_powerdown, .sync_config, .sync_secondary_role,
		.ref_clock_output_one, .ref_clock_output_two, .dclk_reset
	);

	cmb_host_model host_u (.clk, .scs_n, .sclk, .sdi, .sdo);

	// Packs the outputs that mirror register s into its bit layout; any other s packs the single-bit flags.
	function automatic logic [15:0] obs(input logic [3:0] s);
		case (s)
			4'h0: obs = {1'b0, output_phase_select, ~output_swing_low,
				test_pattern_enable, first_channel_powerdown,
				second_channel_powerdown, 2'b00, interleave_en,
				interleave_use_both_inputs, interleave_use_second_input,
				twos_complement_select, timestamp_enable, sdr_select, 2'b00};
			4'h2: obs = i_offset;
			4'h3: obs = i_full_scale;
			4'h4: obs = cal_adjust;
			4'h7: obs = skew_trim;
			4'hA: obs = q_offset;
			4'hB: obs = q_full_scale;
			4'hC: obs = clk_phase_coarse;
			4'hD: obs = clk_phase_fine;
			4'hE: obs = sync_config;
			default: obs = {9'h000, clk_phase_adjust_en,
				cal_value_access_enable, sync_secondary_role,
				ref_clock_output_two, ref_clock_output_one,
				dual_clock_interleave, dclk_reset};
		endcase
	endfunction

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		host_u.xfer(1'b0, a, d, 24, rb);
	endtask

	task automatic rd(input logic [3:0] a);
		host_u.xfer(1'b1, a, 16'h0000, 24, rb);
	endtask

	// Cuts a hung run short and counts cal_start pulses.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cal_start === 1'b1)
			n_cal <= n_cal + 1;
		if (sdo_oe === 1'b1)
			n_oe <= n_oe + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		for (int a = 0; a < 16; a++) begin
			rd(a[3:0]);
			`CHK("reset", CMB_MAPPED[a] ? CMB_REG_RESET[a] : 16'h0000, rb)
		end
		`CHK("sdo_oe read", 1'b1, n_oe != 0)
		`CHK("main out", 16'h2000, obs(4'h0))
		`CHK("flags", 16'h0000, obs(4'hF))
		`CHK("ext mode", 1'b1, extended_mode_active)
		for (int k = 0; k < 13; k++) begin
			wr(rows[k].a, rows[k].d);
			rd(rows[k].a);
			`CHK("readback", CMB_MAPPED[rows[k].a] ? rows[k].d : 16'h0000, rb)
			`CHK("output", rows[k].e, obs(rows[k].s))
		end
		`CHK("sdo_oe idle", 1'b0, sdo_oe)
		wr(4'h0, 16'h7CFC);
		extended_control_scheme <= 1'b0;
		output_phase_pin <= 1'b1;
		range_select_pin <= 1'b0;
		demux_bypass_pin <= 1'b1;
		repeat (5) @(posedge clk);
		`CHK("pin main", 16'h6000, obs(4'h0))
		`CHK("pin range", CMB_FSR_MIN, i_full_scale)
		`CHK("pin q range", CMB_FSR_MIN, q_full_scale)
		`CHK("pin mode", 1'b0, extended_mode_active)
		`CHK("pin skew", 16'h0040, skew_trim)
		`CHK("pin demux", 1'b1, demux_bypass)
		interleave_pin <= 1'b1;
		test_pattern_pin <= 1'b1;
		repeat (5) @(posedge clk);
		`CHK("pin test", 16'h7080, obs(4'h0))
		wr(4'h0, 16'h0010);
		`CHK("pin write", 16'h7080, obs(4'h0))
		extended_control_scheme <= 1'b1;
		repeat (5) @(posedge clk);
		`CHK("ext again", 16'h0010, obs(4'h0))
		`CHK("ext demux", 1'b1, demux_bypass)
		first_powerdown_pin <= 1'b1;
		repeat (5) @(posedge clk);
		`CHK("pd first", 16'h0810, obs(4'h0))
		first_powerdown_pin <= 1'b0;
		second_powerdown_pin <= 1'b1;
		repeat (5) @(posedge clk);
		`CHK("pd second", 16'h0410, obs(4'h0))
		second_powerdown_pin <= 1'b0;
		c0 = n_cal;
		cal_pin <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK("cal pin", c0 + 1, n_cal)
		wr(4'h0, 16'h8000);
		`CHK("cal bit", c0 + 2, n_cal)
		host_u.xfer(1'b0, 4'h2, 16'hBEEF, 12, rb);
		rd(4'h2);
		`CHK("short frame", 16'h1234, rb)
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("rst range", CMB_FSR_MID, i_full_scale)
		`CHK("rst main", 16'h2000, obs(4'h0))
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		rd(4'h0);
		`CHK("rst reg", 16'h2000, rb)
		give_verdict();
	end
endmodule
